// [verilog/bcm_pkg.sv]
// Behaviour
// - Opcode 50h branches relative when carry is clear
// - Branches advance counter by two, then add offset
// - Opcode 70h branches when accumulator is non-zero
// - Opcode 60h branches when accumulator is zero
// - Far call: advance three, push low, high, load target
// - Far jump loads 16-bit target, stack untouched
// - Immediate byte stored at address held in R0/R1
// - Accumulator stored at address held in R0/R1
// - Direct byte copied to address held in R0/R1
// - Opcode 74h loads immediate byte into accumulator
// - Accumulator loaded from address held in R0/R1
// - Accumulator loaded from work register 0 to 7
// - Opcode E5h loads accumulator from direct address
package bcm_pkg;

  // Opcodes and opcode prefixes
  localparam logic [7:0] OP_BR_NO_CARRY = 8'h50;
  localparam logic [7:0] OP_BR_ACC_NZ   = 8'h70;
  localparam logic [7:0] OP_BR_ACC_Z    = 8'h60;
  localparam logic [7:0] OP_FAR_CALL    = 8'h12;
  localparam logic [7:0] OP_FAR_JUMP    = 8'h02;
  localparam logic [6:0] OP_IND_IMM     = 7'h3b;
  localparam logic [6:0] OP_IND_ACC     = 7'h7b;
  localparam logic [6:0] OP_IND_DIR     = 7'h53;
  localparam logic [7:0] OP_ACC_IMM     = 8'h74;
  localparam logic [6:0] OP_ACC_IND     = 7'h73;
  localparam logic [4:0] OP_ACC_REG     = 5'h1d;
  localparam logic [7:0] OP_ACC_DIR     = 8'he5;

  // Reset values
  localparam logic [15:0] PC_RST  = 16'h0000;
  localparam logic [7:0]  SP_RST  = 8'h07;
  localparam logic [7:0]  ACC_RST = 8'h00;

  // Instruction lengths and machine cycle counts
  localparam logic [1:0] LEN_ONE   = 2'h1;
  localparam logic [1:0] LEN_TWO   = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [1:0] MC_ONE    = 2'h1;
  localparam logic [1:0] MC_TWO    = 2'h2;

  // Sequencer states, one-hot
  typedef enum logic [8:0] {
    S_FETCH = 9'h001,
    S_DEC   = 9'h002,
    S_OPA   = 9'h004,
    S_OPB   = 9'h008,
    S_EXEC  = 9'h010,
    S_RD    = 9'h020,
    S_RW    = 9'h040,
    S_WR    = 9'h080,
    S_PUSHL = 9'h100
  } bcm_state_t;

  // Instruction classes
  typedef enum logic [3:0] {
    CL_NONE, CL_BRANCH, CL_CALL, CL_JUMP, CL_IND_IMM, CL_IND_ACC,
    CL_IND_DIR, CL_ACC_IMM, CL_ACC_IND, CL_ACC_REG, CL_ACC_DIR
  } bcm_class_t;

  // Program memory request
  typedef struct packed {
    logic        rd;
    logic [15:0] addr;
  } bcm_code_req_t;

  // Data memory request
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bcm_ram_req_t;

  // Retirement report
  typedef struct packed {
    logic       valid;
    logic [1:0] mcycles;
    logic [7:0] opcode;
  } bcm_retire_t;

endpackage

// [verilog/bcm_dmem.sv]
`timescale 1ns/1ps
// Internal data memory, 256 bytes, registered read
module bcm_dmem (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire bcm_pkg::bcm_ram_req_t req,
  output logic [7:0]              rdata
);

  logic [7:0] mem [256];  // Array has no reset, contents are software's

  // Write port
  always_ff @(posedge sys_clk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

  // Read data register; old data on a write to the same byte
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[req.addr];
    end
  end

endmodule

// [verilog/bcm_core.sv]
`timescale 1ns/1ps
// Branch, call, jump and byte-move sequencer
module bcm_core (
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  output bcm_pkg::bcm_code_req_t      code_req,
  input  wire logic [7:0]             code_rdata,
  input  wire logic                   carry_flag,
  input  wire logic [1:0]             reg_bank,
  output logic [7:0]                  acc,
  output logic [15:0]                 pc,
  output logic [7:0]                  sp,
  output bcm_pkg::bcm_retire_t        retire
);

  bcm_pkg::bcm_state_t   state_r;     // Sequencer state
  bcm_pkg::bcm_class_t   cls_r;       // Class of current instruction
  logic [7:0]            op_r;        // Opcode
  logic [1:0]            len_r;       // Byte count
  logic [1:0]            mc_r;        // Machine cycles to report
  logic [7:0]            b1_r;        // First operand byte
  logic [7:0]            b2_r;        // Second operand byte
  logic [7:0]            ra_r;        // Data memory address
  logic [7:0]            wd_r;        // Data memory write byte
  logic                  ph_r;        // Second pass of a two-read move
  logic [15:0]           pc_r;
  logic [7:0]            sp_r;
  logic [7:0]            acc_r;
  logic [15:0]           ipc_r;       // Address of current opcode
  bcm_pkg::bcm_retire_t  retire_r;
  bcm_pkg::bcm_ram_req_t ram_req;
  logic [7:0]            ram_rdata;

  // Opcode decode, from the byte arriving in S_DEC
  wire d_br   = code_rdata == bcm_pkg::OP_BR_NO_CARRY ||
                code_rdata == bcm_pkg::OP_BR_ACC_NZ ||
                code_rdata == bcm_pkg::OP_BR_ACC_Z;
  wire d_call = code_rdata == bcm_pkg::OP_FAR_CALL;
  wire d_jmp  = code_rdata == bcm_pkg::OP_FAR_JUMP;
  wire d_iimm = code_rdata[7:1] == bcm_pkg::OP_IND_IMM;
  wire d_iacc = code_rdata[7:1] == bcm_pkg::OP_IND_ACC;
  wire d_idir = code_rdata[7:1] == bcm_pkg::OP_IND_DIR;
  wire d_aimm = code_rdata == bcm_pkg::OP_ACC_IMM;
  wire d_aind = code_rdata[7:1] == bcm_pkg::OP_ACC_IND;
  wire d_areg = code_rdata[7:3] == bcm_pkg::OP_ACC_REG;
  wire d_adir = code_rdata == bcm_pkg::OP_ACC_DIR;

  bcm_pkg::bcm_class_t dec_cls;
  assign dec_cls = d_br   ? bcm_pkg::CL_BRANCH  :
                   d_call ? bcm_pkg::CL_CALL    :
                   d_jmp  ? bcm_pkg::CL_JUMP    :
                   d_iimm ? bcm_pkg::CL_IND_IMM :
                   d_iacc ? bcm_pkg::CL_IND_ACC :
                   d_idir ? bcm_pkg::CL_IND_DIR :
                   d_aimm ? bcm_pkg::CL_ACC_IMM :
                   d_aind ? bcm_pkg::CL_ACC_IND :
                   d_areg ? bcm_pkg::CL_ACC_REG :
                   d_adir ? bcm_pkg::CL_ACC_DIR : bcm_pkg::CL_NONE;

  // Length: far transfers three bytes, immediates and directs two
  wire [1:0] dec_len = (d_call || d_jmp) ? bcm_pkg::LEN_THREE :
                       (d_br || d_iimm || d_idir || d_aimm || d_adir) ?
                       bcm_pkg::LEN_TWO : bcm_pkg::LEN_ONE;
  wire [1:0] dec_mc  = (d_br || d_call || d_jmp || d_idir) ?
                       bcm_pkg::MC_TWO : bcm_pkg::MC_ONE;

  // Branch condition and signed target
  wire        acc_zero = acc_r == 8'h00;
  wire        br_take  = (op_r == bcm_pkg::OP_BR_NO_CARRY && !carry_flag) ||
                         (op_r == bcm_pkg::OP_BR_ACC_NZ && !acc_zero) ||
                         (op_r == bcm_pkg::OP_BR_ACC_Z && acc_zero);
  wire [15:0] br_tgt   = pc_r + {{8{b1_r[7]}}, b1_r};
  wire [15:0] far_tgt  = {b1_r, b2_r};
  wire [7:0]  ri_addr  = {3'h0, reg_bank, 2'h0, op_r[0]};  // R0 or R1 pointer
  wire [7:0]  rn_addr  = {3'h0, reg_bank, op_r[2:0]};      // R0..R7
  wire        more_a   = len_r != bcm_pkg::LEN_ONE;
  wire        more_b   = len_r == bcm_pkg::LEN_THREE;
  wire [7:0]  sp_inc   = sp_r + 8'h01;

  // Program memory: counter is the address, advanced on every byte read
  assign code_req.addr = pc_r;
  assign code_req.rd   = state_r == bcm_pkg::S_FETCH ||
                         (state_r == bcm_pkg::S_DEC && dec_len != bcm_pkg::LEN_ONE) ||
                         (state_r == bcm_pkg::S_OPA && more_b);

  // Data memory port: pushes and indirect stores write, all else reads
  assign ram_req.we    = state_r == bcm_pkg::S_WR || state_r == bcm_pkg::S_PUSHL ||
                         (state_r == bcm_pkg::S_RD && ph_r && cls_r == bcm_pkg::CL_CALL);
  assign ram_req.addr  = (state_r == bcm_pkg::S_PUSHL || cls_r == bcm_pkg::CL_CALL) ?
                         sp_inc : ra_r;
  assign ram_req.wdata = (cls_r == bcm_pkg::CL_CALL) ?
                         (ph_r ? pc_r[15:8] : pc_r[7:0]) : wd_r;

  bcm_dmem u_dmem (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .req     (ram_req),
    .rdata   (ram_rdata)
  );

  wire finish = (state_r == bcm_pkg::S_EXEC &&
                 (cls_r == bcm_pkg::CL_BRANCH || cls_r == bcm_pkg::CL_JUMP ||
                  cls_r == bcm_pkg::CL_ACC_IMM || cls_r == bcm_pkg::CL_NONE)) ||
                (state_r == bcm_pkg::S_RW &&
                 (cls_r == bcm_pkg::CL_ACC_REG || cls_r == bcm_pkg::CL_ACC_DIR ||
                  (cls_r == bcm_pkg::CL_ACC_IND && ph_r))) ||
                state_r == bcm_pkg::S_WR ||
                (state_r == bcm_pkg::S_RD && cls_r == bcm_pkg::CL_CALL);

  // Sequencer; call reuses S_RD with ph_r set as its high-byte push
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= bcm_pkg::S_FETCH;
      cls_r   <= bcm_pkg::CL_NONE;
      op_r    <= 8'h00;
      len_r   <= bcm_pkg::LEN_ONE;
      mc_r    <= bcm_pkg::MC_ONE;
      b1_r    <= 8'h00;
      b2_r    <= 8'h00;
      ra_r    <= 8'h00;
      wd_r    <= 8'h00;
      ph_r    <= 1'b0;
      pc_r    <= bcm_pkg::PC_RST;
      sp_r    <= bcm_pkg::SP_RST;
      acc_r   <= bcm_pkg::ACC_RST;
      ipc_r   <= bcm_pkg::PC_RST;
    end else begin
      unique case (state_r)
        bcm_pkg::S_FETCH: begin
          ipc_r   <= pc_r;
          pc_r    <= pc_r + 16'h0001;
          ph_r    <= 1'b0;
          state_r <= bcm_pkg::S_DEC;
        end
        bcm_pkg::S_DEC: begin
          op_r  <= code_rdata;
          cls_r <= dec_cls;
          len_r <= dec_len;
          mc_r  <= dec_mc;
          if (dec_len != bcm_pkg::LEN_ONE) begin
            pc_r    <= pc_r + 16'h0001;
            state_r <= bcm_pkg::S_OPA;
          end else begin
            state_r <= bcm_pkg::S_EXEC;
          end
        end
        bcm_pkg::S_OPA: begin
          b1_r <= code_rdata;
          if (more_b) begin
            pc_r    <= pc_r + 16'h0001;
            state_r <= bcm_pkg::S_OPB;
          end else begin
            state_r <= bcm_pkg::S_EXEC;
          end
        end
        bcm_pkg::S_OPB: begin
          b2_r    <= code_rdata;
          state_r <= bcm_pkg::S_EXEC;
        end
        bcm_pkg::S_EXEC: begin
          state_r <= bcm_pkg::S_RD;
          ra_r    <= rn_addr;
          unique case (cls_r)
            bcm_pkg::CL_BRANCH: begin
              if (br_take) begin
                pc_r <= br_tgt;
              end
              state_r <= bcm_pkg::S_FETCH;
            end
            bcm_pkg::CL_JUMP: begin
              pc_r    <= far_tgt;
              state_r <= bcm_pkg::S_FETCH;
            end
            bcm_pkg::CL_ACC_IMM: begin
              acc_r   <= b1_r;
              state_r <= bcm_pkg::S_FETCH;
            end
            bcm_pkg::CL_CALL: state_r <= bcm_pkg::S_PUSHL;
            bcm_pkg::CL_IND_IMM, bcm_pkg::CL_IND_ACC, bcm_pkg::CL_ACC_IND: begin
              ra_r <= ri_addr;
            end
            bcm_pkg::CL_IND_DIR, bcm_pkg::CL_ACC_DIR: ra_r <= b1_r;
            bcm_pkg::CL_ACC_REG: ra_r <= rn_addr;
            default: state_r <= bcm_pkg::S_FETCH;  // Opcodes outside this block
          endcase
        end
        bcm_pkg::S_PUSHL: begin
          sp_r    <= sp_inc;
          ph_r    <= 1'b1;
          state_r <= bcm_pkg::S_RD;
        end
        bcm_pkg::S_RD: begin
          if (cls_r == bcm_pkg::CL_CALL) begin
            sp_r    <= sp_inc;
            pc_r    <= far_tgt;
            state_r <= bcm_pkg::S_FETCH;
          end else begin
            state_r <= bcm_pkg::S_RW;
          end
        end
        bcm_pkg::S_RW: begin
          state_r <= bcm_pkg::S_WR;
          ra_r    <= ram_rdata;  // Pointer read from R0/R1
          unique case (cls_r)
            bcm_pkg::CL_IND_IMM: wd_r <= b1_r;
            bcm_pkg::CL_IND_ACC: wd_r <= acc_r;
            bcm_pkg::CL_IND_DIR: begin
              if (!ph_r) begin
                wd_r    <= ram_rdata;
                ra_r    <= ri_addr;
                ph_r    <= 1'b1;
                state_r <= bcm_pkg::S_RD;
              end
            end
            bcm_pkg::CL_ACC_IND: begin
              if (ph_r) begin
                acc_r   <= ram_rdata;
                state_r <= bcm_pkg::S_FETCH;
              end else begin
                ph_r    <= 1'b1;
                state_r <= bcm_pkg::S_RD;
              end
            end
            default: begin
              acc_r   <= ram_rdata;
              state_r <= bcm_pkg::S_FETCH;
            end
          endcase
        end
        bcm_pkg::S_WR: state_r <= bcm_pkg::S_FETCH;
        default: state_r <= bcm_pkg::S_FETCH;  // Illegal one-hot code
      endcase
    end
  end

  // Retirement pulse, one clock after the last step
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      retire_r <= '0;
    end else begin
      retire_r.valid   <= finish;
      retire_r.mcycles <= mc_r;
      retire_r.opcode  <= op_r;
    end
  end

  assign acc    = acc_r;
  assign pc     = pc_r;
  assign sp     = sp_r;
  assign retire = retire_r;

  // Checks
  wire in_exec = state_r == bcm_pkg::S_EXEC;
  wire ex_br   = in_exec && cls_r == bcm_pkg::CL_BRANCH;

  property p_no_carry_br;
    @(posedge sys_clk) disable iff (!resetn)
    ex_br && op_r == bcm_pkg::OP_BR_NO_CARRY && carry_flag |=>
      pc_r == ipc_r + 16'h0002;
  endproperty
  a_no_carry_br: assert property (p_no_carry_br) else $error("branch taken with carry");

  property p_br_len;
    @(posedge sys_clk) disable iff (!resetn)
    ex_br |-> pc_r == ipc_r + 16'h0002;
  endproperty
  a_br_len: assert property (p_br_len) else $error("branch counter not advanced by 2");

  property p_nz_take;
    @(posedge sys_clk) disable iff (!resetn)
    ex_br && op_r == bcm_pkg::OP_BR_ACC_NZ && acc_r != 8'h00 |=>
      pc_r == $past(pc_r) + {{8{$past(b1_r[7])}}, $past(b1_r)};
  endproperty
  a_nz_take: assert property (p_nz_take) else $error("nonzero branch wrong target");

  property p_z_skip;
    @(posedge sys_clk) disable iff (!resetn)
    ex_br && op_r == bcm_pkg::OP_BR_ACC_Z && acc_r != 8'h00 |=> $stable(pc_r);
  endproperty
  a_z_skip: assert property (p_z_skip) else $error("zero branch taken on nonzero");

  property p_call_push;
    @(posedge sys_clk) disable iff (!resetn)
    in_exec && cls_r == bcm_pkg::CL_CALL |=> ##2
      (pc_r == far_tgt && sp_r == $past(sp_r, 3) + 8'h02);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push or target wrong");

  property p_jump;
    @(posedge sys_clk) disable iff (!resetn)
    in_exec && cls_r == bcm_pkg::CL_JUMP |=> pc_r == far_tgt && $stable(sp_r);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target or stack wrong");

  property p_ind_imm;
    @(posedge sys_clk) disable iff (!resetn)
    state_r == bcm_pkg::S_WR && cls_r == bcm_pkg::CL_IND_IMM |->
      ram_req.we && ram_req.wdata == b1_r;
  endproperty
  a_ind_imm: assert property (p_ind_imm) else $error("indirect immediate store wrong");

  property p_ind_acc;
    @(posedge sys_clk) disable iff (!resetn)
    state_r == bcm_pkg::S_WR && cls_r == bcm_pkg::CL_IND_ACC |->
      ram_req.wdata == acc_r && ram_req.addr == $past(ram_rdata);
  endproperty
  a_ind_acc: assert property (p_ind_acc) else $error("indirect acc store wrong");

  property p_acc_imm;
    @(posedge sys_clk) disable iff (!resetn)
    in_exec && cls_r == bcm_pkg::CL_ACC_IMM |=> acc_r == $past(b1_r);
  endproperty
  a_acc_imm: assert property (p_acc_imm) else $error("immediate acc load wrong");

  c_call: cover property (@(posedge sys_clk) in_exec && cls_r == bcm_pkg::CL_CALL);
  c_br_taken: cover property (@(posedge sys_clk) ex_br && br_take);
  c_ind_dir: cover property (@(posedge sys_clk)
    state_r == bcm_pkg::S_WR && cls_r == bcm_pkg::CL_IND_DIR);

endmodule

// [testbench/bcm_rom_model.sv]
`timescale 1ns/1ps
// Program memory partner: synchronous ROM, one clock of latency
module bcm_rom_model (
  input  wire logic                  sys_clk,
  input  wire bcm_pkg::bcm_code_req_t req,
  output logic [7:0]                 rdata
);
  // Code image, filled by the bench before reset is released
  logic [7:0] mem [0:65535];

  initial begin
    // Unwritten bytes read as 00h, a harmless filler opcode
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
    rdata = 8'h00;
  end

  // Byte appears one edge after the strobe
  always @(posedge sys_clk) begin
    if (req.rd === 1'b1) begin
      rdata <= mem[req.addr];
    end else begin
      // Nothing requested: stale byte is not held, so a late consumer sees junk
      rdata <= ~rdata;
    end
  end
endmodule

// [testbench/branch_call_move_exec_test.sv]
`timescale 1ns/1ps
// Self-checking bench: bench-side instruction model compared at every retire
module branch_call_move_exec_test;
  logic                   sys_clk;    // 250 MHz core clock
  logic                   resetn;     // Async reset, active low
  bcm_pkg::bcm_code_req_t code_req;   // Program fetch request
  logic [7:0]             code_rdata; // Program byte from partner
  logic                   carry_flag; // Randomised carry
  logic [1:0]             reg_bank;   // Work register bank
  logic [7:0]             acc;        // Accumulator seen
  logic [15:0]            pc;         // Program counter seen
  logic [7:0]             sp;         // Stack pointer seen
  bcm_pkg::bcm_retire_t   retire;     // Retirement report

  int          n_errors;  // Mismatches
  int          tests_run; // Comparisons
  int          cyc;       // Cycle counter for the hang limit
  int          seed;      // Random seed
  logic [15:0] ptr;       // Program builder cursor
  logic [15:0] halt_a;    // Address of the final self jump
  logic [15:0] mpc;       // Model program counter
  logic [7:0]  macc;      // Model accumulator
  logic [7:0]  msp;       // Model stack pointer
  logic [7:0]  mram [0:255]; // Model data memory, unknown until written

  bcm_core bcm_core_i (.sys_clk(sys_clk), .resetn(resetn), .code_req(code_req),
    .code_rdata(code_rdata), .carry_flag(carry_flag), .reg_bank(reg_bank),
    .acc(acc), .pc(pc), .sp(sp), .retire(retire));

  bcm_rom_model bcm_rom_model_i (.sys_clk(sys_clk), .req(code_req), .rdata(code_rdata));

  // Clock
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  // Hang limit, far above the longest program walk
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      test_done();
    end
  end

  // Compare one value
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Place one program byte
  task automatic emit(input logic [7:0] b);
    bcm_rom_model_i.mem[ptr] = b;
    ptr = ptr + 16'h0001;
  endtask

  // Reset for two cycles, then check the chosen reset state
  task automatic do_reset();
    @(negedge sys_clk);
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("rst pc", pc, bcm_pkg::PC_RST);
    check("rst sp", 16'(sp), 16'(bcm_pkg::SP_RST));
    check("rst acc", 16'(acc), 16'(bcm_pkg::ACC_RST));
    check("rst retire", 16'(retire.valid), 16'h0000);
    check("rst fetch", {15'h0000, code_req.rd}, 16'h0001);
    resetn = 1'b1;
    mpc = 16'h0000;
    macc = 8'h00;
    msp = 8'h07;
    $display("test reset done");
  endtask

  // Wait for one retire, run the model one instruction, compare
  task automatic step();
    logic [7:0]  op, b1, b2, p;
    logic [15:0] np;
    logic [1:0]  mc;
    int          n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (retire.valid !== 1'b1 && n < 400);
    op = bcm_rom_model_i.mem[mpc];
    b1 = bcm_rom_model_i.mem[mpc + 16'h0001];
    b2 = bcm_rom_model_i.mem[mpc + 16'h0002];
    p = mram[{3'b000, reg_bank, 2'b00, op[0]}];
    mc = 2'h1;
    np = mpc + 16'h0001;
    casez (op)
      // Relative branches: advance two, signed offset when condition holds
      8'h50, 8'h60, 8'h70: begin
        mc = 2'h2;
        np = mpc + 16'h0002;
        if ((op == 8'h50 && carry_flag == 1'b0) || (op == 8'h60 && macc == 8'h00)
            || (op == 8'h70 && macc != 8'h00)) begin
          np = np + {{8{b1[7]}}, b1};
        end
      end
      // Far call: push return low then high, load target high byte first
      bcm_pkg::OP_FAR_CALL: begin
        mc = 2'h2;
        np = mpc + 16'h0003;
        mram[msp + 8'h01] = np[7:0];
        mram[msp + 8'h02] = np[15:8];
        msp = msp + 8'h02;
        np = {b1, b2};
      end
      bcm_pkg::OP_FAR_JUMP: begin
        mc = 2'h2;
        np = {b1, b2};
      end
      8'h74: begin
        macc = b1;
        np = mpc + 16'h0002;
      end
      8'he5: begin
        macc = mram[b1];
        np = mpc + 16'h0002;
      end
      8'b0111011?: begin
        mram[p] = b1;
        np = mpc + 16'h0002;
      end
      8'b1111011?: mram[p] = macc;
      8'b1010011?: begin
        mc = 2'h2;
        mram[p] = mram[b1];
        np = mpc + 16'h0002;
      end
      8'b1110011?: macc = mram[p];
      8'b11101???: macc = mram[{3'b000, reg_bank, op[2:0]}];
      default: ; // Filler opcode: one byte, nothing else
    endcase
    check("opcode", 16'(retire.opcode), 16'(op));
    check("mcycles", 16'(retire.mcycles), 16'(mc));
    check("pc", pc, np);
    check("acc", 16'(acc), 16'(macc));
    check("sp", 16'(sp), 16'(msp));
    mpc = np;
    // New carry only between instructions, off the sampling edge
    carry_flag = 1'($random(seed));
  endtask

  initial begin
    logic [7:0]  d1, d2, off;
    logic [15:0] a;
    n_errors = 0;
    tests_run = 0;
    cyc = 0;
    seed = 32'hcc80;
    resetn = 1'b0;
    carry_flag = 1'b0;
    reg_bank = 2'h1;
    for (int i = 0; i < 256; i++) begin
      mram[i] = 8'hxx;
    end
    // Let the code image clear itself first, or the filler pass could wipe the program
    @(negedge sys_clk);
    // Jump then call from 0030h: bank 1 R0 = 33h, R1 = 00h via the pushed return
    ptr = 16'h0000;
    emit(8'h02); emit(8'h00); emit(8'h30);
    ptr = 16'h0030;
    emit(8'h12); emit(8'h01); emit(8'h00);
    ptr = 16'h0100;
    for (int k = 0; k < 8; k++) begin
      d1 = 8'($random(seed));
      d2 = 8'($random(seed));
      a = ptr + 16'h0003;
      emit(8'h12); emit(a[15:8]); emit(a[7:0]);
      // Moves through pointers, direct and register forms
      emit(8'h74); emit(d1); emit(8'hf6);
      emit(8'h74); emit(8'h00); emit(8'he5); emit(8'h33);
      emit(8'h77); emit(d2); emit(8'he7);
      emit(8'ha6); emit(8'h00); emit(8'he6);
      emit(8'he8 | 8'(k % 4));
      // Accumulator zero on odd passes, so both branch outcomes occur
      emit(8'h74); emit(k[0] ? 8'h00 : (d1 | 8'h01));
      for (int j = 2; j >= 0; j--) begin
        off = 8'($random(seed)) & 8'h7f;
        if (k == 0) begin
          off = 8'h7f;
        end
        emit(j == 0 ? 8'h50 : (j == 1 ? 8'h60 : 8'h70));
        emit(off);
        repeat (off) emit(8'h00);
      end
    end
    // Backward branch by exactly -128 to a landing jump
    emit(8'h74); emit(8'h00);
    a = ptr;
    emit(8'h02); emit(8'((a + 16'd129) >> 8)); emit(8'(a + 16'd129));
    emit(8'h02); emit(8'((a + 16'd131) >> 8)); emit(8'(a + 16'd131));
    ptr = a + 16'd129;
    emit(8'h60); emit(8'h80);
    halt_a = ptr;
    emit(8'h02); emit(halt_a[15:8]); emit(halt_a[7:0]);
    do_reset();
    while (mpc != halt_a) begin
      step();
    end
    // Self jump twice: counter must stay put
    step();
    step();
    $display("test program done");
    // Reset in mid-run must restore the start state
    do_reset();
    test_done();
  end
endmodule
